// ### bstp_dr_chain.sv
// capture, shift and update stages of one serial test register
// assumes strobes are one-cycle pulses; needs LEN of two or more
`timescale 1ns/1ns
`default_nettype none

module bstp_dr_chain
  import bstp_pkg::*;
#(
  parameter int             LEN     = 2,
  parameter logic [LEN-1:0] RST_VAL = '0
) (
  input  wire logic           sys_clk_i,
  input  wire logic           reset_n_i,
  input  wire logic           clear_i,
  input  wire logic           capture_i,
  input  wire logic           shift_i,
  input  wire logic           update_i,
  input  wire logic           ser_i,
  input  wire logic [LEN-1:0] par_i,
  output logic                ser_o,
  output logic      [LEN-1:0] upd_o
);

  typedef struct packed {
    logic [LEN-1:0] sh;
    logic [LEN-1:0] upd;
  } bstp_chain_s;

  bstp_chain_s st_reg;
  bstp_chain_s st_next;

  always_comb begin
    st_next = st_reg;
    if (capture_i) begin
      st_next.sh = par_i;
    end else if (shift_i) begin
      // new bit enters at the far end, lsb leaves first
      st_next.sh = {ser_i, st_reg.sh[LEN-1:1]};
    end
    if (clear_i) begin
      st_next.upd = RST_VAL;
    end else if (update_i) begin
      st_next.upd = st_reg.sh;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_reg.sh  <= '0;
      st_reg.upd <= RST_VAL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ser_o = st_reg.sh[0];
  assign upd_o = st_reg.upd;

endmodule

`default_nettype wire

// ### bstp_pkg.sv
// constants and types shared by the boundary scan test access port
// assumes every user imports the whole package
`default_nettype none

package bstp_pkg;

  // ==========================================================
  // widths and defaults
  localparam int          IR_WIDTH_DEF  = 4;
  localparam int          CHAIN_LEN_DEF = 8;
  localparam int          ID_WIDTH      = 32;
  localparam int          TMS_ONES_CNT  = 5;
  localparam logic [2:0]  TMS_ONES_MAX  = 3'h4;
  localparam logic [2:0]  TMS_ONES_RST  = 3'h0;

  // ==========================================================
  // instruction codes and capture patterns
  localparam logic [3:0]  OP_EXTEST_DEF = 4'h0;
  localparam logic [3:0]  OP_SAMPLE_DEF = 4'h1;
  localparam logic [3:0]  OP_IDCODE_DEF = 4'h2;
  localparam logic [3:0]  OP_BYPASS_DEF = 4'hF;
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;
  // identification value is arbitrary; bit 0 must stay one
  localparam logic [31:0] IDCODE_DEF    = 32'h0A5A_5001;

  // ==========================================================
  // reset values
  localparam logic        TDO_RST       = 1'b0;
  localparam logic        TDO_OE_RST    = 1'b0;
  localparam logic        BYPASS_RST    = 1'b0;
  localparam logic        EXTEST_RST    = 1'b0;
  localparam logic        TCK_D_RST     = 1'b0;
  localparam logic        TRST_D_RST    = 1'b0;

  // ==========================================================
  // controller states
  typedef enum logic [15:0] {
    ST_TLR      = 16'h0001,
    ST_RTI      = 16'h0002,
    ST_SEL_DR   = 16'h0004,
    ST_CAP_DR   = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR   = 16'h0100,
    ST_SEL_IR   = 16'h0200,
    ST_CAP_IR   = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR   = 16'h8000
  } bstp_state_e;

endpackage

`default_nettype wire

// ### bstp_sync.sv
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no bus coherence is given
`timescale 1ns/1ns
`default_nettype none

module bstp_sync
  import bstp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } bstp_sync_s;

  bstp_sync_s st_reg;
  bstp_sync_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = async_i;
    st_next.stab = st_reg.meta;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.stab;

endmodule

`default_nettype wire

// ### bstp_tap_port.sv
// test access port: controller, instruction path and data registers
// assumes test pins are asynchronous to sys_clk_i and test clock is
// far slower than sys_clk_i, so every test clock edge is seen
`timescale 1ns/1ns
`default_nettype none

// Function
// - test reset low forces Test-Logic-Reset at once
// - sample mode select and data on rising edges
// - data output changes only on falling edges
// - output driven only in the two shift states
// - five mode-select ones reach Test-Logic-Reset
// - sixteen-state controller stepped by mode select
// - four-bit instruction register selects operation
// - serial data routed into selected register
// - plain boundary test of DC pins only
// - identification value readable through the port
// - shift instruction in, apply at Update-IR
module bstp_tap_port
  import bstp_pkg::*;
#(
  parameter int                  IR_WIDTH  = IR_WIDTH_DEF,
  parameter int                  CHAIN_LEN = CHAIN_LEN_DEF,
  parameter logic [IR_WIDTH-1:0] OP_EXTEST = OP_EXTEST_DEF,
  parameter logic [IR_WIDTH-1:0] OP_SAMPLE = OP_SAMPLE_DEF,
  parameter logic [IR_WIDTH-1:0] OP_IDCODE = OP_IDCODE_DEF,
  parameter logic [IR_WIDTH-1:0] OP_BYPASS = OP_BYPASS_DEF,
  parameter logic [ID_WIDTH-1:0] ID_VALUE  = IDCODE_DEF
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 tck_i,
  input  wire logic                 tms_i,
  input  wire logic                 tdi_i,
  input  wire logic                 trst_n_i,
  input  wire logic [CHAIN_LEN-1:0] pin_in_i,
  output logic                      tdo_o,
  output logic                      tdo_oe_o,
  output logic      [CHAIN_LEN-1:0] bcell_out_o,
  output logic                      extest_o,
  output bstp_state_e               tap_state_o
);

  // ==========================================================
  // state
  typedef struct packed {
    bstp_state_e state;
    logic        tck_d;
    logic        trst_n_d;
    logic        bypass;
    logic        tdo;
    logic        tdo_oe;
    logic        extest;
    logic [2:0]  tms_ones;
  } bstp_port_s;

  bstp_port_s st_reg;
  bstp_port_s st_next;

  logic                 tck_s;
  logic                 tms_s;
  logic                 tdi_s;
  logic                 trst_n_s;
  logic [CHAIN_LEN-1:0] pin_s;
  logic                 tck_rise;
  logic                 tck_fall;
  logic                 in_tlr;
  logic                 clr_ir;
  logic [IR_WIDTH-1:0]  ir_cur;
  logic                 ir_ser;
  logic                 bnd_ser;
  logic                 id_ser;
  logic                 bnd_sel;
  logic                 id_sel;
  logic                 byp_sel;
  logic                 cap_ir;
  logic                 sh_ir;
  logic                 upd_ir;
  logic                 cap_dr;
  logic                 sh_dr;
  logic                 upd_dr;

  // ==========================================================
  // controller state graph
  function automatic bstp_state_e tap_next(bstp_state_e cur, logic tms);
    bstp_state_e nxt;
    nxt = ST_TLR;
    case (cur)
      ST_TLR:      nxt = tms ? ST_TLR    : ST_RTI;
      ST_RTI:      nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR:   nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: nxt = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: nxt = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: nxt = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR:   nxt = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR:   nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: nxt = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: nxt = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: nxt = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   nxt = tms ? ST_SEL_DR : ST_RTI;
      default:     nxt = ST_TLR;
    endcase
    return nxt;
  endfunction

  // ==========================================================
  // pin synchronisers
  bstp_sync #(
    .WIDTH (4)
  ) u_sync_tap (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({tck_i, tms_i, tdi_i, trst_n_i}),
    .sync_o    ({tck_s, tms_s, tdi_s, trst_n_s})
  );

  bstp_sync #(
    .WIDTH (CHAIN_LEN)
  ) u_sync_pins (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (pin_in_i),
    .sync_o    (pin_s)
  );

  // ==========================================================
  // test clock edges and register strobes
  // edges count only once the pins have flushed through the synchronisers,
  // else a test clock idling high looks like a rise just after reset
  assign tck_rise = tck_s & ~st_reg.tck_d & st_reg.trst_n_d;
  assign tck_fall = ~tck_s & st_reg.tck_d & st_reg.trst_n_d;
  assign in_tlr   = (st_reg.state == ST_TLR);
  assign clr_ir   = ~trst_n_s | in_tlr;

  // the instruction decode picks which data register sits in the path
  assign bnd_sel  = (ir_cur == OP_EXTEST) || (ir_cur == OP_SAMPLE);
  assign id_sel   = (ir_cur == OP_IDCODE);
  assign byp_sel  = ~bnd_sel & ~id_sel;

  assign cap_ir   = trst_n_s & tck_rise & (st_reg.state == ST_CAP_IR);
  assign sh_ir    = trst_n_s & tck_rise & (st_reg.state == ST_SHIFT_IR);
  assign upd_ir   = trst_n_s & tck_fall & (st_reg.state == ST_UPD_IR);
  assign cap_dr   = trst_n_s & tck_rise & (st_reg.state == ST_CAP_DR);
  assign sh_dr    = trst_n_s & tck_rise & (st_reg.state == ST_SHIFT_DR);
  assign upd_dr   = trst_n_s & tck_fall & (st_reg.state == ST_UPD_DR);

  // ==========================================================
  // instruction, boundary and identification registers
  bstp_dr_chain #(
    .LEN     (IR_WIDTH),
    .RST_VAL (OP_IDCODE)
  ) u_ir (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (clr_ir),
    .capture_i (cap_ir),
    .shift_i   (sh_ir),
    .update_i  (upd_ir),
    .ser_i     (tdi_s),
    .par_i     (IR_CAPTURE[IR_WIDTH-1:0]),
    .ser_o     (ir_ser),
    .upd_o     (ir_cur)
  );

  // only static levels are captured and driven: DC pins
  bstp_dr_chain #(
    .LEN     (CHAIN_LEN),
    .RST_VAL ('0)
  ) u_boundary_cell_chain (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (~trst_n_s),
    .capture_i (cap_dr & bnd_sel),
    .shift_i   (sh_dr & bnd_sel),
    .update_i  (upd_dr & bnd_sel),
    .ser_i     (tdi_s),
    .par_i     (pin_s),
    .ser_o     (bnd_ser),
    .upd_o     (bcell_out_o)
  );

  bstp_dr_chain #(
    .LEN     (ID_WIDTH),
    .RST_VAL ('0)
  ) u_ident (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clear_i   (1'b0),
    .capture_i (cap_dr & id_sel),
    .shift_i   (sh_dr & id_sel),
    .update_i  (1'b0),
    .ser_i     (tdi_s),
    .par_i     (ID_VALUE),
    .ser_o     (id_ser),
    .upd_o     ()
  );

  // ==========================================================
  // controller, bypass bit and serial output
  always_comb begin
    st_next        = st_reg;
    st_next.tck_d  = tck_s;
    st_next.trst_n_d = trst_n_s;
    st_next.extest = (ir_cur == OP_EXTEST);
    if (!trst_n_s) begin
      st_next.state    = ST_TLR;
      st_next.tdo_oe   = 1'b0;
      st_next.tms_ones = TMS_ONES_RST;
    end else begin
      if (tck_rise) begin
        st_next.state = tap_next(st_reg.state, tms_s);
        if (!tms_s) begin
          st_next.tms_ones = TMS_ONES_RST;
        end else if (st_reg.tms_ones != TMS_ONES_MAX) begin
          st_next.tms_ones = 3'(st_reg.tms_ones + 3'h1);
        end
      end
      if (cap_dr) begin
        st_next.bypass = 1'b0;
      end else if (sh_dr && byp_sel) begin
        st_next.bypass = tdi_s;
      end
      if (tck_fall) begin
        // enable follows the state on the falling edge, as data does
        st_next.tdo_oe = (st_reg.state == ST_SHIFT_DR) ||
                         (st_reg.state == ST_SHIFT_IR);
        if (st_reg.state == ST_SHIFT_IR) begin
          st_next.tdo = ir_ser;
        end else if (st_reg.state == ST_SHIFT_DR) begin
          st_next.tdo = bnd_sel ? bnd_ser : (id_sel ? id_ser : st_reg.bypass);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_reg.state    <= ST_TLR;
      st_reg.tck_d    <= TCK_D_RST;
      st_reg.trst_n_d <= TRST_D_RST;
      st_reg.bypass   <= BYPASS_RST;
      st_reg.tdo      <= TDO_RST;
      st_reg.tdo_oe   <= TDO_OE_RST;
      st_reg.extest   <= EXTEST_RST;
      st_reg.tms_ones <= TMS_ONES_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tdo_o       = st_reg.tdo;
  assign tdo_oe_o    = st_reg.tdo_oe;
  assign extest_o    = st_reg.extest;
  assign tap_state_o = st_reg.state;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  trst_forces_tlr_a: assert property (
    !trst_n_s |=> (st_reg.state == ST_TLR) && !st_reg.tdo_oe
  ) else $error("test reset did not force Test-Logic-Reset");

  fsm_no_edge_a: assert property (
    (trst_n_s && !tck_rise) |=> $stable(st_reg.state)
  ) else $error("controller moved without a rising test clock");

  fsm_step_a: assert property (
    (trst_n_s && tck_rise && st_reg.state == ST_SEL_DR && !tms_s)
      |=> (st_reg.state == ST_CAP_DR) ##1 (st_reg.state == ST_CAP_DR)
  ) else $error("Select-DR with mode select low did not reach Capture-DR");

  tdo_fall_only_a: assert property (
    $changed(tdo_o) |-> $past(tck_fall)
  ) else $error("data output changed away from a falling edge");

  oe_shift_only_a: assert property (
    $rose(tdo_oe_o) |-> $past(tck_fall) &&
      ($past(st_reg.state) == ST_SHIFT_DR || $past(st_reg.state) == ST_SHIFT_IR)
  ) else $error("output enabled outside a shift state");

  five_ones_a: assert property (
    (trst_n_s && tck_rise && tms_s && st_reg.tms_ones == TMS_ONES_MAX)
      |=> st_reg.state == ST_TLR
  ) else $error("five mode-select ones did not reach Test-Logic-Reset");

  ir_apply_a: assert property (
    $changed(ir_cur) |-> $past(upd_ir) || $past(clr_ir)
  ) else $error("instruction changed outside Update-IR or reset");

  tlr_default_a: assert property (
    in_tlr |=> ir_cur == OP_IDCODE
  ) else $error("Test-Logic-Reset did not load the default instruction");

  bypass_path_a: assert property (
    (sh_dr && byp_sel) |=> st_reg.bypass == $past(tdi_s)
  ) else $error("bypass bit did not take the serial input");

  id_capture_a: assert property (
    (cap_dr && id_sel) |=> id_ser == ID_VALUE[0]
  ) else $error("identification value not captured");

  extest_flag_a: assert property (
    ##1 extest_o == ($past(ir_cur) == OP_EXTEST)
  ) else $error("extest flag does not follow the instruction");

  shift_ir_c: cover property (st_reg.state == ST_SHIFT_IR && tdo_oe_o);
  id_read_c:  cover property (st_reg.state == ST_UPD_DR && id_sel);
  extest_c:   cover property ($rose(extest_o));
  trst_c:     cover property ($fell(trst_n_s) && st_reg.state == ST_SHIFT_DR);

endmodule

`default_nettype wire

// ### bstp_tester.sv
// tester model for the five-wire test link of the port
// assumes sys_clk_i is the bench clock; one test clock period is 8 of its cycles
`timescale 1ns/1ns
`default_nettype none

module bstp_tester (
  input  wire logic sys_clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o
);
  // ==========================================================
  // link state
  logic tdo_last = 1'b0;
  logic tdo_line;

  initial begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
  end

  // a released line has no pull: show the inverse of the last driven level
  always @(posedge sys_clk_i) begin
    if (tdo_oe_i) begin
      tdo_last <= tdo_i;
    end
  end
  assign tdo_line = tdo_oe_i ? tdo_i : ~tdo_last;

  // ==========================================================
  // one period: fall with new mode and data, rise 4 cycles later
  task automatic cycle(input logic m, input logic d, output logic o);
    @(posedge sys_clk_i);
    tck_o <= 1'b0;
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge sys_clk_i);
    tck_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    o = tdo_line;
  endtask

  task automatic set_trst(input logic v);
    @(posedge sys_clk_i);
    trst_n_o <= v;
  endtask
endmodule

`default_nettype wire

// ### test_boundary_scan_tap_port.sv
// self-checking bench of the test access port driven by bstp_tester
// assumes a 50 MHz system clock and a 160 ns test clock
`timescale 1ns/1ns
`default_nettype none

module test_boundary_scan_tap_port
  import bstp_pkg::*;
;
  localparam int          N  = 8;
  // identification value is arbitrary; bit 0 kept one
  localparam logic [31:0] ID = 32'h1357_9BDF;

  logic         sys_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         tck, tms, tdi, trst_n, tdo, tdo_oe, extest, tck_q, tdo_q;
  logic [N-1:0] pin_in = '0;
  logic [N-1:0] bcell;
  bstp_state_e  st;
  bstp_state_e  exp_st = ST_TLR;
  logic [3:0]   ir_sh = '0;
  logic [3:0]   cur_ir = OP_IDCODE_DEF;
  int           mismatches = 0;
  int           compares = 0;
  int           cyc = 0;
  int           since_fall = 0;
  int           seed = 32'h6F0ADDAD;

  bstp_tap_port #(.CHAIN_LEN(N), .ID_VALUE(ID)) dut_u (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .trst_n_i(trst_n), .pin_in_i(pin_in), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .bcell_out_o(bcell), .extest_o(extest), .tap_state_o(st));

  bstp_tester tester_u (
    .sys_clk_i(sys_clk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // checking and reference
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask

  function automatic bstp_state_e nxt(bstp_state_e s, logic m);
    case (s)
      ST_TLR:                       return m ? ST_TLR : ST_RTI;
      ST_RTI, ST_UPD_DR, ST_UPD_IR: return m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR:                    return m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR, ST_SHIFT_DR:       return m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:                  return m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:                  return m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:                  return m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_SEL_IR:                    return m ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR, ST_SHIFT_IR:       return m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:                  return m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:                  return m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:                  return m ? ST_UPD_IR : ST_SHIFT_IR;
      default:                      return ST_TLR;
    endcase
  endfunction

  // one test clock period, checked against the reference controller
  task automatic step(input logic m, input logic d, output logic o);
    tester_u.cycle(m, d, o);
    if (exp_st == ST_UPD_IR) cur_ir = ir_sh;
    if (exp_st == ST_TLR) cur_ir = OP_IDCODE_DEF;
    chk("oe", 32'(exp_st inside {ST_SHIFT_DR, ST_SHIFT_IR}), 32'(tdo_oe));
    chk("extest", 32'(cur_ir == OP_EXTEST_DEF), 32'(extest));
    if (exp_st == ST_CAP_IR) ir_sh = IR_CAPTURE;
    if (exp_st == ST_SHIFT_IR) ir_sh = {d, ir_sh[3:1]};
    exp_st = nxt(exp_st, m);
    chk("state", 32'(exp_st), 32'(st));
  endtask

  // from idle: scan n bits through the instruction or data path, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] di,
                      output logic [31:0] dq);
    logic o;
    dq = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, di[i], o);
      dq[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask

  // ==========================================================
  // output may only move shortly after a test clock fall
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    tck_q <= tck;
    tdo_q <= tdo;
    since_fall <= ((tck_q & ~tck) | ~trst_n) ? 0 : since_fall + 1;
    if (reset_n && tdo !== tdo_q) begin
      compares++;
      if (since_fall > 5) begin
        mismatches++;
        $display("[ERR] tdo timing expected fall seen %0d", since_fall);
      end
    end
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] d;
    logic        o;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    for (int k = 0; k < 12; k++) begin
      repeat (4 + k * 3) begin
        d = $random(seed);
        step(d[0], d[1], o);
      end
      repeat (5) step(1'b1, d[2], o);
      chk("tlr", 32'(ST_TLR), 32'(st));
    end
    step(1'b0, 1'b0, o);
    scan(1'b0, 32, $random(seed), q);
    chk("idcode", ID, q);
    for (int c = 3; c < 16; c++) begin
      scan(1'b1, 4, 32'(c), q);
      chk("ir capture", 32'(IR_CAPTURE), q);
      d = $random(seed);
      scan(1'b0, N, d, q);
      chk("bypass", 32'({d[N-2:0], 1'b0}), q);
    end
    @(posedge sys_clk);
    pin_in <= N'($random(seed));
    scan(1'b1, 4, 32'(OP_SAMPLE_DEF), q);
    d = $random(seed);
    scan(1'b0, N, d, q);
    chk("sample", 32'(pin_in), q);
    chk("preload", 32'(d[N-1:0]), 32'(bcell));
    scan(1'b1, 4, 32'(OP_EXTEST_DEF), q);
    chk("extest hold", 32'(d[N-1:0]), 32'(bcell));
    repeat (2) step(1'b0, 1'b0, o);
    step(1'b1, 1'b0, o);
    repeat (5) step(1'b0, 1'b1, o);
    tester_u.set_trst(1'b0);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("trst state", 32'(ST_TLR), 32'(st));
    chk("trst oe", 32'(1'b0), 32'(tdo_oe));
    @(negedge sys_clk);
    chk("trst extest", 32'(1'b0), 32'(extest));
    chk("trst bcell", 32'(1'b0), 32'(bcell));
    tester_u.set_trst(1'b1);
    exp_st = ST_TLR;
    repeat (4) @(posedge sys_clk);
    step(1'b0, 1'b0, o);
    scan(1'b0, 32, $random(seed), q);
    chk("idcode again", ID, q);
    report_and_stop();
  end
endmodule

`default_nettype wire
